//--- verilog/lbcc_pkg.sv
// package for the common led blink control: register map, fields, rate tables, types
package lbcc_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_PERIOD_NS = 1_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned WINDOW_MS      = 1000;
  localparam int unsigned THRESH_UNIT_MS = 42;

  // widths
  localparam int unsigned REG_W   = 16;
  localparam int unsigned IDX_W   = 16;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned MS_W    = 14;
  localparam int unsigned WIN_W   = 11;
  localparam int unsigned CODE_W  = 4;
  localparam int unsigned TH_W    = 5;
  localparam int unsigned NUM_MODES = 3;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LED_CFG0 = 16'h40C0;
  localparam logic [IDX_W-1:0] IDX_COMMON   = 16'h40C1;
  localparam logic [IDX_W-1:0] IDX_RATE     = 16'h40C2;
  localparam logic [IDX_W-1:0] IDX_LED_CFG1 = 16'h40C3;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 16'h40C4;

  // common control fields
  localparam int unsigned COM_COL_SEL_HI = 15;
  localparam int unsigned COM_INVERT     = 9;
  localparam int unsigned COM_LPBK_SUPP  = 8;
  localparam int unsigned COM_JAB_SUPP   = 7;
  localparam int unsigned COM_COL_SEL_LO = 6;
  localparam int unsigned COM_LVL_EN     = 5;
  localparam int unsigned COM_TH_LSB     = 0;
  localparam logic [REG_W-1:0] COM_RESET = 16'h80CC;
  localparam logic [REG_W-1:0] COM_MASK  = 16'h83FF;

  // blink rate fields
  localparam int unsigned RATE_M0_LSB = 12;
  localparam int unsigned RATE_M1_LSB = 8;
  localparam int unsigned RATE_M2_LSB = 4;
  localparam logic [REG_W-1:0] RATE_RESET = 16'hEC70;
  localparam logic [REG_W-1:0] RATE_MASK  = 16'hFFF0;

  // per-led config fields
  localparam int unsigned CFG_COL_EN = 3;
  localparam int unsigned CFG_RX_EN  = 8;
  localparam int unsigned CFG_TX_EN  = 9;
  localparam logic [REG_W-1:0] CFG_RESET = 16'h0300;
  localparam logic [REG_W-1:0] CFG_MASK  = 16'h0308;

  // status fields
  localparam int unsigned STS_HEAVY_RX = 0;
  localparam int unsigned STS_HEAVY_TX = 1;
  localparam int unsigned STS_LED_LSB  = 2;

  // ahb
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // period and off time in ms per rate code, code 15 leftmost
  localparam logic [15:0][MS_W-1:0] RATE_PERIOD_MS = {
    14'h0064, 14'h007D, 14'h00A6, 14'h014D, 14'h014D, 14'h01F4, 14'h03E8, 14'h03E8,
    14'h07D0, 14'h0BB8, 14'h0FA0, 14'h1770, 14'h1CE8, 14'h1F40, 14'h24B8, 14'h2710};
  localparam logic [15:0][MS_W-1:0] RATE_OFF_MS = {
    14'h0032, 14'h003E, 14'h0053, 14'h00A6, 14'h00A6, 14'h00FA, 14'h00A0, 14'h00A0,
    14'h0140, 14'h014A, 14'h0140, 14'h0294, 14'h029A, 14'h0280, 14'h0292, 14'h0258};

  typedef enum logic [1:0] {LBCC_MODE0, LBCC_MODE1, LBCC_MODE2} lbcc_mode_t;

  typedef struct packed {
    logic link_up;
    logic collision;
    logic tx_active;
    logic rx_active;
    logic loopback;
    logic jabber;
  } lbcc_phy_status_t;

  function automatic logic [MS_W-1:0] period_ms(input logic [CODE_W-1:0] code);
    period_ms = RATE_PERIOD_MS[code];
  endfunction

  function automatic logic [MS_W-1:0] off_ms(input logic [CODE_W-1:0] code);
    off_ms = RATE_OFF_MS[code];
  endfunction

endpackage

//--- verilog/lbcc_top.sv
// common led blink control with ahb-lite register slave
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module lbcc_top #(
  parameter int unsigned TICK_CYCLES = lbcc_pkg::TICK_CYCLES,
  parameter int unsigned NUM_LEDS    = 2
) (
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  // phy status from the same clock domain
  input  wire lbcc_pkg::lbcc_phy_status_t    phy_status,
  // leds, high means lit
  output logic      [NUM_LEDS-1:0]           led_on
);

  localparam int unsigned TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int unsigned MS_W   = lbcc_pkg::MS_W;
  localparam int unsigned WIN_W  = lbcc_pkg::WIN_W;
  localparam int unsigned REG_W  = lbcc_pkg::REG_W;
  localparam int unsigned IDX_W  = lbcc_pkg::IDX_W;
  localparam int unsigned CODE_W = lbcc_pkg::CODE_W;
  localparam int unsigned NMODE  = lbcc_pkg::NUM_MODES;
  localparam logic [TICK_W-1:0] TICK_LAST   = TICK_W'(TICK_CYCLES - 1);
  localparam logic [WIN_W-1:0]  WIN_LAST    = WIN_W'(lbcc_pkg::WINDOW_MS - 1);
  localparam logic [WIN_W-1:0]  THRESH_UNIT = WIN_W'(lbcc_pkg::THRESH_UNIT_MS);

  // ---------------- bus slave ----------------
  logic [IDX_W-1:0] addr_idx_q;
  logic             wr_pend_q;
  logic             rd_pend_q;
  logic [REG_W-1:0] com_q;
  logic [REG_W-1:0] rate_q;
  logic [REG_W-1:0] cfg_q [NUM_LEDS];
  logic             heavy_rx_q;
  logic             heavy_tx_q;
  logic [NUM_LEDS-1:0] led_q;

  wire              addr_phase = hsel & hready & (htrans == lbcc_pkg::HTRANS_NONSEQ);
  wire              addr_upper_zero = (haddr[31:IDX_W+lbcc_pkg::IDX_LSB] == '0);
  wire [IDX_W-1:0]  addr_idx = addr_upper_zero
                               ? haddr[IDX_W+lbcc_pkg::IDX_LSB-1:lbcc_pkg::IDX_LSB]
                               : '1;
  wire [REG_W-1:0]  wdata16 = hwdata[REG_W-1:0];
  wire              wr_com  = wr_pend_q & (addr_idx_q == lbcc_pkg::IDX_COMMON);
  wire              wr_rate = wr_pend_q & (addr_idx_q == lbcc_pkg::IDX_RATE);
  wire              wr_cfg0 = wr_pend_q & (addr_idx_q == lbcc_pkg::IDX_LED_CFG0);
  wire              wr_cfg1 = wr_pend_q & (addr_idx_q == lbcc_pkg::IDX_LED_CFG1);

  // zero wait states, every transfer answers okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_idx_q <= '0;
      wr_pend_q  <= 1'b0;
      rd_pend_q  <= 1'b0;
    end else if (hready) begin
      addr_idx_q <= addr_idx;
      wr_pend_q  <= addr_phase & hwrite;
      rd_pend_q  <= addr_phase & ~hwrite;
    end
  end

  // writable bits only; reserved bits hold zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      com_q  <= lbcc_pkg::COM_RESET;
      rate_q <= lbcc_pkg::RATE_RESET;
    end else begin
      if (wr_com) begin
        com_q <= wdata16 & lbcc_pkg::COM_MASK;
      end
      if (wr_rate) begin
        rate_q <= wdata16 & lbcc_pkg::RATE_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q[0] <= lbcc_pkg::CFG_RESET;
      cfg_q[1] <= lbcc_pkg::CFG_RESET;
    end else begin
      if (wr_cfg0) begin
        cfg_q[0] <= wdata16 & lbcc_pkg::CFG_MASK;
      end
      if (wr_cfg1) begin
        cfg_q[1] <= wdata16 & lbcc_pkg::CFG_MASK;
      end
    end
  end

  // status word shows live block state
  logic [REG_W-1:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[lbcc_pkg::STS_HEAVY_RX] = heavy_rx_q;
    status_word[lbcc_pkg::STS_HEAVY_TX] = heavy_tx_q;
    status_word[lbcc_pkg::STS_LED_LSB +: NUM_LEDS] = led_q;
  end

  // read mux over flops during the data phase; unmapped reads give zero
  logic [REG_W-1:0] rd_word;
  always_comb begin
    unique case (addr_idx_q)
      lbcc_pkg::IDX_COMMON:   rd_word = com_q;
      lbcc_pkg::IDX_RATE:     rd_word = rate_q;
      lbcc_pkg::IDX_LED_CFG0: rd_word = cfg_q[0];
      lbcc_pkg::IDX_LED_CFG1: rd_word = cfg_q[1];
      lbcc_pkg::IDX_STATUS:   rd_word = status_word;
      default:                rd_word = '0;
    endcase
  end
  assign hrdata = rd_pend_q ? {16'h0000, rd_word} : 32'h0000_0000;

  // ---------------- control fields ----------------
  wire                invert   = com_q[lbcc_pkg::COM_INVERT];
  wire                lpbk_sup = com_q[lbcc_pkg::COM_LPBK_SUPP];
  wire                jab_sup  = com_q[lbcc_pkg::COM_JAB_SUPP];
  wire                col_sel  = com_q[lbcc_pkg::COM_COL_SEL_HI]
                               | com_q[lbcc_pkg::COM_COL_SEL_LO];
  wire                lvl_en   = com_q[lbcc_pkg::COM_LVL_EN];
  wire [lbcc_pkg::TH_W-1:0] thresh = com_q[lbcc_pkg::COM_TH_LSB +: lbcc_pkg::TH_W];
  wire [CODE_W-1:0]   code [NMODE];
  assign code[0] = rate_q[lbcc_pkg::RATE_M0_LSB +: CODE_W];
  assign code[1] = rate_q[lbcc_pkg::RATE_M1_LSB +: CODE_W];
  assign code[2] = rate_q[lbcc_pkg::RATE_M2_LSB +: CODE_W];

  // ---------------- shared millisecond prescaler ----------------
  logic [TICK_W-1:0] presc_q;
  wire               tick = (presc_q == TICK_LAST);

  // one free counter for all leds, so equal modes never drift apart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_q <= '0;
    end else begin
      presc_q <= tick ? '0 : presc_q + TICK_W'(1);
    end
  end

  // ---------------- blink waveforms per mode ----------------
  logic [MS_W-1:0]  phase_q [NMODE];
  logic [NMODE-1:0] wave;

  for (genvar m = 0; m < NMODE; m++) begin : g_mode
    wire [MS_W-1:0] period = lbcc_pkg::period_ms(code[m]);
    wire [MS_W-1:0] off_t  = lbcc_pkg::off_ms(code[m]);
    // a shorter code written mid-period wraps at once, not after a long overrun
    wire            wrap   = (phase_q[m] >= period - MS_W'(1));
    wire            in_off = (phase_q[m] < off_t);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        phase_q[m] <= '0;
      end else if (tick) begin
        phase_q[m] <= wrap ? '0 : phase_q[m] + MS_W'(1);
      end
    end

    // normal: off share first, then lit; inverted: lit only for that share
    assign wave[m] = in_off ^ ~invert;
  end

  // ---------------- traffic weight ----------------
  logic [WIN_W-1:0] win_q;
  logic [WIN_W-1:0] rx_cnt_q;
  logic [WIN_W-1:0] tx_cnt_q;
  wire              win_end  = tick & (win_q == WIN_LAST);
  wire [WIN_W-1:0]  limit    = WIN_W'(thresh) * THRESH_UNIT;
  wire              rx_tick  = tick & phy_status.rx_active;
  wire              tx_tick  = tick & phy_status.tx_active;
  // totals include the closing millisecond, so a full second counts 1000 ticks
  wire [WIN_W-1:0]  rx_total = rx_cnt_q + WIN_W'(rx_tick);
  wire [WIN_W-1:0]  tx_total = tx_cnt_q + WIN_W'(tx_tick);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q    <= '0;
      rx_cnt_q <= '0;
      tx_cnt_q <= '0;
    end else if (tick) begin
      win_q    <= win_end ? '0 : win_q + WIN_W'(1);
      rx_cnt_q <= win_end ? '0 : rx_total;
      tx_cnt_q <= win_end ? '0 : tx_total;
    end
  end

  // verdict of the last full second holds through the next one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      heavy_rx_q <= 1'b0;
      heavy_tx_q <= 1'b0;
    end else if (win_end) begin
      heavy_rx_q <= (rx_total > limit);
      heavy_tx_q <= (tx_total > limit);
    end
  end

  wire heavy = heavy_rx_q | heavy_tx_q;
  wire no_blink = (phy_status.loopback & lpbk_sup)
                | (phy_status.jabber & jab_sup);

  // mode choices common to all leds
  wire lbcc_pkg::lbcc_mode_t col_mode = col_sel ? lbcc_pkg::LBCC_MODE2
                                                : lbcc_pkg::LBCC_MODE1;
  wire lbcc_pkg::lbcc_mode_t act_mode = (lvl_en & heavy) ? lbcc_pkg::LBCC_MODE0
                                                         : lbcc_pkg::LBCC_MODE1;

  // ---------------- per-led decision ----------------
  logic [NUM_LEDS-1:0] led_d;

  for (genvar n = 0; n < NUM_LEDS; n++) begin : g_led
    wire col_req = phy_status.link_up & phy_status.collision
                 & cfg_q[n][lbcc_pkg::CFG_COL_EN];
    wire act_req = phy_status.link_up
                 & ((phy_status.tx_active & cfg_q[n][lbcc_pkg::CFG_TX_EN])
                  | (phy_status.rx_active & cfg_q[n][lbcc_pkg::CFG_RX_EN]));
    // collision outranks activity
    wire lbcc_pkg::lbcc_mode_t sel = col_req ? col_mode : act_mode;
    wire blink = (col_req | act_req) & ~no_blink;
    // without a blink the led simply shows link state
    assign led_d[n] = blink ? wave[sel] : phy_status.link_up;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_q <= '0;
    end else begin
      led_q <= led_d;
    end
  end

  assign led_on = led_q;

endmodule

`default_nettype wire

//--- testbench/lbcc_top_chk.sv
// port-level assertions for the common led blink control
`timescale 1ns/1ps
`default_nettype none
module lbcc_top_chk #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned NUM_LEDS    = 2
) (
  // clock and reset
  input wire logic                       hclk,
  input wire logic                       hresetn,
  // ahb-lite slave
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [2:0]                 hsize,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic [31:0]                hrdata,
  // phy status and leds
  input wire lbcc_pkg::lbcc_phy_status_t phy_status,
  input wire logic [NUM_LEDS-1:0]        led_on
);
  logic        take;
  logic        rd_q;
  logic        wr_q;
  logic        hit_q;
  logic [15:0] com_q;
  assign take = hsel & hready & (htrans == lbcc_pkg::HTRANS_NONSEQ);
  // shadow of the common register, so suppression can be judged from the ports alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      hit_q <= 1'b0;
      com_q <= lbcc_pkg::COM_RESET;
    end else begin
      rd_q  <= take & ~hwrite;
      wr_q  <= take & hwrite;
      hit_q <= take & (haddr[31:2] == {14'h0000, lbcc_pkg::IDX_COMMON});
      if (wr_q && hit_q) begin
        com_q <= hwdata[15:0] & lbcc_pkg::COM_MASK;
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_rdata_quiet: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("hrdata not zero outside a read");
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("hrdata upper half not zero");
  a_common_read: assert property (rd_q && hit_q |-> hrdata == {16'h0000, com_q})
    else $error("common register read mismatch");
  a_link_dark: assert property ((!phy_status.link_up)[*3] |-> led_on == '0)
    else $error("led lit with link down");
  a_idle_steady: assert property ((phy_status.link_up && !phy_status.collision &&
      !phy_status.tx_active && !phy_status.rx_active)[*3] |-> &led_on)
    else $error("idle led not steady");
  a_loop_quiet: assert property ((phy_status.link_up && phy_status.loopback && com_q[8])[*3]
      |-> &led_on) else $error("led blinks in suppressed loopback");
  a_jab_quiet: assert property ((phy_status.link_up && phy_status.jabber && com_q[7])[*3]
      |-> &led_on) else $error("led blinks in suppressed jabber");
  c_read_common: cover property (rd_q && hit_q);
  c_loop_supp: cover property (phy_status.loopback && com_q[8]);
  c_collision: cover property (phy_status.link_up && phy_status.collision);
endmodule
bind lbcc_top lbcc_top_chk #(.TICK_CYCLES(TICK_CYCLES), .NUM_LEDS(NUM_LEDS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .phy_status(phy_status), .led_on(led_on));
`default_nettype wire

//--- testbench/lbcc_led_board.sv
// board model of the status leds: counts lit cycles of each led
`timescale 1ns/1ps
`default_nettype none
module lbcc_led_board #(
  parameter int unsigned NUM_LEDS = 2
) (
  // clock
  input  wire logic                      hclk,
  // start of a measurement
  input  wire logic                      clr,
  // led drive, high lit
  input  wire logic [NUM_LEDS-1:0]       led_on,
  // lit cycles since clr; 16 bits hold one 4000-cycle window
  output logic      [NUM_LEDS-1:0][15:0] lit_cnt
);
  always @(posedge hclk) begin
    for (int i = 0; i < NUM_LEDS; i++) begin
      lit_cnt[i] <= clr ? 16'h0000 : lit_cnt[i] + 16'(led_on[i]);
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench: registers over ahb-lite and led blink patterns
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // 4 clocks a ms keeps a one-second window at 4000 cycles
  localparam int unsigned TICKS = 4;
  localparam int unsigned WIN   = 4000;
  // lit cycles per window: mode0 code 9, mode1 code 15, mode2 code 14
  localparam logic [15:0] M0 = 16'h0D20;
  localparam logic [15:0] M0I = 16'h0280;
  localparam logic [15:0] M1 = 16'h07D0;
  localparam logic [15:0] M2 = 16'h07E0;
  localparam logic [15:0] M2I = 16'h07C0;
  localparam logic [15:0] ON = 16'h0FA0;
  typedef struct {logic [15:0] idx; logic wr; logic [15:0] wd; logic [15:0] exp;} lbcc_reg_t;
  typedef struct {logic [15:0] com; logic [5:0] phy; logic [15:0] e0; logic [15:0] e1;} lbcc_blk_t;
  logic             hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       led_on;
  logic [1:0][15:0] lit_cnt;
  lbcc_pkg::lbcc_phy_status_t phy;
  int               fails, n_tests;
  lbcc_reg_t regs [9] = '{'{16'h40C1, 0, 0, 16'h80CC}, '{16'h40C2, 0, 0, 16'hEC70},
    '{16'h40C1, 1, 16'hFFFF, 16'h83FF}, '{16'h40C1, 1, 0, 0}, '{16'h40C2, 1, 16'hFFFF, 16'hFFF0},
    '{16'h40C2, 1, 16'h9FE0, 16'h9FE0}, '{16'h40C8, 1, 16'h1234, 0},
    '{16'h40C0, 1, 16'hFFFF, 16'h0308}, '{16'h40C3, 1, 16'h0008, 16'h0008}};
  // phy bits: link, collision, tx, rx, loopback, jabber
  lbcc_blk_t blks [12] = '{'{0, 6'h28, M1, ON}, '{16'h8000, 6'h30, M2, M2},
    '{16'h0040, 6'h30, M2, M2}, '{0, 6'h30, M1, M1}, '{16'h0100, 6'h2A, ON, ON},
    '{0, 6'h2A, M1, ON}, '{16'h0080, 6'h29, ON, ON}, '{0, 6'h29, M1, ON},
    '{0, 6'h10, 0, 0}, '{16'h8200, 6'h30, M2I, M2I}, '{0, 6'h24, M1, ON},
    '{0, 6'h20, ON, ON}};
  assign hready = hreadyout;
  lbcc_top #(.TICK_CYCLES(TICKS), .NUM_LEDS(2)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .phy_status(phy), .led_on(led_on));
  lbcc_led_board #(.NUM_LEDS(2)) u_board (.hclk(hclk), .clr(clr), .led_on(led_on),
    .lit_cnt(lit_cnt));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [15:0] wd,
                     output logic [31:0] rdv);
    @(posedge hclk);
    haddr  <= {14'h0000, idx, 2'b00};
    htrans <= lbcc_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsel   <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  // counts lit cycles over one full window; any phase gives the same count
  task automatic measure(input logic [15:0] e0, input logic [15:0] e1);
    @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (WIN) @(posedge hclk);
    #1;
    check("led0 lit cycles", {16'h0000, e0}, {16'h0000, lit_cnt[0]});
    check("led1 lit cycles", {16'h0000, e1}, {16'h0000, lit_cnt[1]});
  endtask
  task automatic test_done;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    repeat (95000) @(posedge hclk);
    fails++;
    test_done();
  end
  initial begin
    {hresetn, hsel, hwrite, clr, htrans, haddr, hwdata, phy} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) begin
      if (regs[i].wr) bus(regs[i].idx, 1'b1, regs[i].wd, rd);
      bus(regs[i].idx, 1'b0, 16'h0000, rd);
      check("register", {16'h0000, regs[i].exp}, rd);
    end
    foreach (blks[i]) begin
      bus(16'h40C1, 1'b1, blks[i].com, rd);
      phy <= blks[i].phy;
      repeat (100) @(posedge hclk);
      measure(blks[i].e0, blks[i].e1);
    end
    // code 8 on mode 2 must blink like code 9
    bus(16'h40C2, 1'b1, 16'h9F80, rd);
    bus(16'h40C1, 1'b1, 16'h8000, rd);
    phy <= 6'h30;
    repeat (100) @(posedge hclk);
    measure(M0, M0);
    // heavy traffic needs a whole window closed before the mode 0 pattern shows
    bus(16'h40C1, 1'b1, 16'h0020, rd);
    phy <= 6'h28;
    repeat (2 * WIN) @(posedge hclk);
    measure(M0, ON);
    bus(16'h40C4, 1'b0, 16'h0000, rd);
    check("heavy flags", 32'h0000_0002, {30'h0, rd[1:0]});
    bus(16'h40C1, 1'b1, 16'h0220, rd);
    measure(M0I, ON);
    bus(16'h40C1, 1'b1, 16'h003F, rd);
    repeat (2 * WIN) @(posedge hclk);
    measure(M1, ON);
    bus(16'h40C4, 1'b0, 16'h0000, rd);
    check("heavy flags", 32'h0000_0000, {30'h0, rd[1:0]});
    // second reset restarts every phase, so the slowest code can be timed from it
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    #1;
    check("led in reset", 32'h0000_0000, {30'h0, led_on});
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(16'h40C1, 1'b0, 16'h0000, rd);
    check("register", 32'h0000_80CC, rd);
    bus(16'h40C2, 1'b1, 16'hE070, rd);
    // about 400 ms in: inside the 600 ms off share of code 0
    repeat (1590) @(posedge hclk);
    #1;
    check("slow code dark", 32'h0000_0000, {30'h0, led_on});
    // about 700 ms in: lit part of code 0, dark for the reset code of mode 1
    repeat (1200) @(posedge hclk);
    #1;
    check("slow code lit", 32'h0000_0003, {30'h0, led_on});
    test_done();
  end
endmodule
`default_nettype wire
